// ==== shared/esf_pkg.sv ====
// Types shared by the sideband flag codec
package esf_pkg;
   typedef struct packed {
      logic [5:0] unused;
      logic class_b;
      logic class_a;
      logic crc_ovf;
      logic crc_inv;
      logic crc;
      logic error;
      logic event_frame;
      logic corr_upd;
      logic time_upd;
      logic [7:0] offset;
      logic udp_fix;
      logic peer_delay;
      logic upd_en;
      logic [3:0] tag;
   } esf_txflags_t;
   typedef struct packed {
      logic [15:0] unused;
      logic [4:0] order;
      logic [7:0] err_type;
      logic error;
   } esf_rxflags_t;
   typedef enum logic [1:0] {ESF_IDLE = 2'b00, ESF_FIRST = 2'b01, ESF_BODY = 2'b10} esf_pkt_t;
endpackage : esf_pkg

// ==== shared/esf_regs.svh ====
// Register offsets, field positions and reset values of the sideband flag codec
`ifndef ESF_REGS_SVH
`define ESF_REGS_SVH
`define ESF_OFS_CTRL 12'h000
`define ESF_OFS_STATUS 12'h004
`define ESF_OFS_MASK 12'h008
`define ESF_OFS_TXTAG 12'h00c
`define ESF_OFS_TXSEEN 12'h010
`define ESF_OFS_RXSEEN 12'h014
`define ESF_CTRL_RST 32'h0000_0000
`define ESF_MASK_RST 32'h0000_0000
`define ESF_FLD_LO 261
`define ESF_FLD_HI 290
`define ESF_BIT_UPDATE 4
`define ESF_BIT_PEER 5
`define ESF_BIT_UDP 6
`define ESF_OFF_LO 7
`define ESF_OFF_HI 14
`define ESF_BIT_TIME 15
`define ESF_BIT_CORR 16
`define ESF_BIT_EVENT 17
`define ESF_BIT_ERR 18
`define ESF_BIT_CRC 19
`define ESF_BIT_CRCINV 20
`define ESF_BIT_CRCOVF 21
`define ESF_BIT_CLSA 22
`define ESF_BIT_CLSB 23
`define ESF_MIN_OFFSET 8'h10
`define ESF_ST_TXDONE 0
`define ESF_ST_RXERR 1
`define ESF_ST_TXBAD 2
`define ESF_ST_RXDONE 3
`endif

// ==== shared/esf_side_if.sv ====
// Decoded transmit sideband controls passed from the decoder to the top
`timescale 1ns/100ps
interface esf_side_if;
   logic word_ok;
   logic upd_en;
   logic peer_delay;
   logic udp_fix;
   logic time_upd;
   logic corr_upd;
   logic [7:0] offset;
   logic [3:0] tag;
   logic bad;
   modport src (output word_ok, upd_en, peer_delay, udp_fix, time_upd, corr_upd, offset, tag, bad);
   modport dst (input word_ok, upd_en, peer_delay, udp_fix, time_upd, corr_upd, offset, tag, bad);
endinterface : esf_side_if

// ==== src/esf_codec.sv ====
// Ethernet sideband flag codec: transmit decode, receive encode, AHB-Lite registers
`timescale 1ns/100ps
`include "esf_regs.svh"
module esf_codec
   import esf_pkg::*;
#(
   parameter int DATA_W = 293
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   input wire logic tx_valid,
   input wire logic tx_sop,
   input wire logic tx_eop,
   input wire logic [DATA_W-1:0] tx_data,
   output logic tx_ready,
   input wire logic tx_sent,
   output logic [3:0] tx_status_tag,
   output logic tx_status_valid,
   output logic [63:0] tx_timestamp,
   output logic tx_upd_en,
   output logic tx_peer_delay,
   output logic tx_udp_fix,
   output logic tx_time_upd,
   output logic tx_corr_upd,
   output logic [7:0] tx_offset,
   output logic [6:0] tx_marks,
   input wire logic rx_in_valid,
   input wire logic rx_in_sop,
   input wire logic rx_in_eop,
   input wire logic [255:0] rx_in_data,
   input wire logic [29:0] rx_in_timestamp,
   input wire logic rx_in_error,
   input wire logic [7:0] rx_in_err_type,
   input wire logic [4:0] rx_in_order,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic rx_sop,
   output logic rx_eop,
   output logic [DATA_W-1:0] rx_data
);
   // Field slice below needs bits up to 290
   if (DATA_W < 291)
   begin : g_width_check
      $error("DATA_W must cover the sideband field");
   end

   esf_side_if side ();
   logic [29:0] tx_field;
   logic [29:0] rx_field;
   logic [31:0] ctrl_r;
   logic [31:0] status_r;
   logic [31:0] status_nxt;
   logic [31:0] mask_r;
   logic [3:0] held_tag_r;
   logic tag_pend_r;
   logic [15:0] tx_seen_r;
   logic [15:0] rx_seen_r;
   esf_pkt_t tx_state_r;
   esf_pkt_t tx_state_nxt;
   logic [63:0] ts_first_r;
   logic wr_pend_r;
   logic [11:0] addr_r;
   logic [3:0] ev;
   logic [31:0] rd_mux;
   logic tx_go;
   logic rx_go;

   assign tx_field = tx_data[`ESF_FLD_HI:`ESF_FLD_LO];
   assign tx_go = tx_valid && tx_ready;

   esf_tx_decode u_dec (
      .valid(tx_go),
      .sop(tx_sop),
      .field(tx_field),
      .side(side)
   );

   esf_rx_encode u_enc (
      .sop(rx_in_sop),
      .timestamp(rx_in_timestamp),
      .error(rx_in_error),
      .err_type(rx_in_err_type),
      .order(rx_in_order),
      .field(rx_field)
   );

   // Bit 0 of control pauses transmit intake
   // No receive buffer: a word offered while the output is held is lost
   assign tx_ready = !ctrl_r[0];
   assign rx_go = rx_in_valid && (rx_ready || !rx_valid);

   // Packet position, read back in the tag register
   always_comb
   begin
      tx_state_nxt = tx_state_r;
      unique case (tx_state_r)
         ESF_IDLE:
         begin
            if (tx_go && !tx_eop)
               tx_state_nxt = tx_sop ? ESF_FIRST : ESF_BODY;
         end
         ESF_FIRST, ESF_BODY:
         begin
            if (tx_go)
               tx_state_nxt = tx_eop ? ESF_IDLE : (tx_sop ? ESF_FIRST : ESF_BODY);
         end
         default: tx_state_nxt = ESF_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_state_r <= ESF_IDLE;
      else
         tx_state_r <= tx_state_nxt;
   end

   // Timestamp of first word kept for the time update
   // Upper 34 bits stay zero; the fabric supplies only 30
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ts_first_r <= 64'h0;
      else if (tx_go && tx_sop)
         ts_first_r <= {34'h0, tx_field};
   end
   assign tx_timestamp = ts_first_r;

   // Update controls registered for the downstream editor
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_upd_en <= 1'b0;
         tx_peer_delay <= 1'b0;
         tx_udp_fix <= 1'b0;
         tx_time_upd <= 1'b0;
         tx_corr_upd <= 1'b0;
         tx_offset <= 8'h00;
         tx_marks <= 7'h00;
      end
      else if (tx_go && !tx_sop)
      begin
         tx_upd_en <= side.upd_en;
         tx_peer_delay <= side.peer_delay;
         tx_udp_fix <= side.udp_fix;
         tx_time_upd <= side.time_upd;
         tx_corr_upd <= side.corr_upd;
         tx_offset <= side.offset;
         tx_marks <= tx_field[`ESF_BIT_CLSB:`ESF_BIT_EVENT];
      end
   end

   // Tag held from an event frame until the frame is reported sent
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         held_tag_r <= 4'h0;
         tag_pend_r <= 1'b0;
      end
      else if (side.word_ok)
      begin
         held_tag_r <= side.tag;
         tag_pend_r <= 1'b1;
      end
      else if (tx_sent)
         tag_pend_r <= 1'b0;
   end

   // Report only frames whose tag is still pending

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_status_tag <= 4'h0;
         tx_status_valid <= 1'b0;
      end
      else
      begin
         tx_status_valid <= tx_sent && tag_pend_r;
         if (tx_sent && tag_pend_r)
            tx_status_tag <= held_tag_r;
      end
   end

   // Receive output word
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_valid <= 1'b0;
         rx_sop <= 1'b0;
         rx_eop <= 1'b0;
         rx_data <= '0;
      end
      else if (rx_go)
      begin
         rx_valid <= 1'b1;
         rx_sop <= rx_in_sop;
         rx_eop <= rx_in_eop;
         rx_data <= DATA_W'({rx_field, 5'h00, rx_in_data});
      end
      else if (rx_ready)
         rx_valid <= 1'b0;
   end

   // Event counters
   // Counters wrap; software takes differences
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_seen_r <= 16'h0;
         rx_seen_r <= 16'h0;
      end
      else
      begin
         if (tx_go && tx_eop)
            tx_seen_r <= tx_seen_r + 16'h1;
         if (rx_go && rx_in_eop)
            rx_seen_r <= rx_seen_r + 16'h1;
      end
   end

   // Interrupt events
   always_comb
   begin
      ev = 4'h0;
      ev[`ESF_ST_TXDONE] = tx_sent && tag_pend_r;
      ev[`ESF_ST_RXERR] = rx_go && !rx_in_sop && rx_in_error;
      ev[`ESF_ST_TXBAD] = side.bad;
      ev[`ESF_ST_RXDONE] = rx_go && rx_in_eop;
   end

   // AHB-Lite slave, zero wait states
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         addr_r <= 12'h000;
      end
      else if (hready)
      begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         addr_r <= haddr;
      end
   end

   // Every register answers at once, so no wait states
   assign hreadyout = 1'b1;
   // Nothing is refused; unmapped reads give zero
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_r <= `ESF_CTRL_RST;
         mask_r <= `ESF_MASK_RST;
      end
      else if (wr_pend_r)
      begin
         if (addr_r == `ESF_OFS_CTRL)
            ctrl_r <= {31'h0, hwdata[0]};
         if (addr_r == `ESF_OFS_MASK)
            mask_r <= {28'h0, hwdata[3:0]};
      end
   end

   // Set wins over the write-one clear
   always_comb
   begin
      status_nxt = status_r;
      if (wr_pend_r && addr_r == `ESF_OFS_STATUS)
         status_nxt = status_r & ~hwdata;
      status_nxt = status_nxt | {28'h0, ev};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         status_r <= 32'h0;
      else
         status_r <= status_nxt;
   end

   // Level output; stays high until software clears or masks
   assign irq = |(status_r & mask_r);

   // Decode on the address phase; status shows this cycle's events too
   always_comb
   begin
      case (haddr)
         `ESF_OFS_CTRL: rd_mux = ctrl_r;
         `ESF_OFS_STATUS: rd_mux = status_nxt;
         `ESF_OFS_MASK: rd_mux = mask_r;
         `ESF_OFS_TXTAG: rd_mux = {25'h0, tx_state_r, tag_pend_r, held_tag_r};
         `ESF_OFS_TXSEEN: rd_mux = {16'h0, tx_seen_r};
         `ESF_OFS_RXSEEN: rd_mux = {16'h0, rx_seen_r};
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data registered at the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (hready && hsel && htrans[1] && !hwrite)
         hrdata <= rd_mux;
   end
endmodule : esf_codec

// ==== src/esf_rx_encode.sv ====
// Builds the receive sideband field
`timescale 1ns/100ps
module esf_rx_encode
   import esf_pkg::*;
(
   input wire logic sop,
   input wire logic [29:0] timestamp,
   input wire logic error,
   input wire logic [7:0] err_type,
   input wire logic [4:0] order,
   output logic [29:0] field
);
   esf_rxflags_t f;
   always_comb
   begin
      f.error = error;
      f.err_type = err_type;
      f.order = order;
      f.unused = 16'h0000;
      field = sop ? timestamp : 30'(f);
   end
endmodule : esf_rx_encode

// ==== src/esf_tx_decode.sv ====
// Combinational decoder of a transmit sideband flag word
`timescale 1ns/100ps
`include "esf_regs.svh"
module esf_tx_decode
   import esf_pkg::*;
(
   input wire logic valid,
   input wire logic sop,
   input wire logic [29:0] field,
   esf_side_if.src side
);
   esf_txflags_t f;
   logic act;
   assign f = esf_txflags_t'(field);
   // Vector only counts on a non-first word of an event frame
   assign act = valid && !sop && f.event_frame;
   assign side.word_ok = act;
   assign side.tag = act ? f.tag : 4'h0;
   // Higher bits ignored unless update enabled
   assign side.upd_en = act && f.upd_en;
   assign side.peer_delay = side.upd_en && f.peer_delay;
   assign side.udp_fix = side.upd_en && f.udp_fix;
   assign side.time_upd = side.upd_en && f.time_upd;
   assign side.corr_upd = side.upd_en && f.corr_upd;
   assign side.offset = side.upd_en ? f.offset : 8'h00;
   // Flag illegal combinations the far side must avoid
   assign side.bad = valid && !sop && ((f.unused != 6'h00) ||
      (side.upd_en && (f.time_upd || f.corr_upd) && f.offset < `ESF_MIN_OFFSET) ||
      (side.time_upd && (f.peer_delay || f.udp_fix)) || (side.corr_upd && f.peer_delay));
endmodule : esf_tx_decode

// ==== tb/esf_codec_sva.sv ====
// Port-level assertions for the sideband flag codec
`timescale 1ns/100ps
module esf_codec_sva #(
   parameter int DATA_W = 293
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tx_valid,
   input wire logic tx_sop,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic tx_ready,
   input wire logic [63:0] tx_timestamp,
   input wire logic tx_upd_en,
   input wire logic tx_peer_delay,
   input wire logic [7:0] tx_offset,
   input wire logic [6:0] tx_marks,
   input wire logic rx_in_valid,
   input wire logic rx_in_sop,
   input wire logic [29:0] rx_in_timestamp,
   input wire logic rx_in_error,
   input wire logic [7:0] rx_in_err_type,
   input wire logic [4:0] rx_in_order,
   input wire logic rx_ready,
   input wire logic rx_valid,
   input wire logic [DATA_W-1:0] rx_data
);
   logic [29:0] tf;
   logic [6:0] mk;
   logic ev;
   logic u4;
   logic p5;
   assign tf = tx_data[290:261];
   assign mk = tf[23:17];
   assign ev = tf[17];
   assign u4 = tf[4];
   assign p5 = tf[5];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence tx_body;
      tx_valid && tx_ready && !tx_sop;
   endsequence
   sequence rx_take;
      rx_in_valid && (rx_ready || !rx_valid);
   endsequence
   a_sop_stamp: assert property (tx_valid && tx_ready && tx_sop |=> tx_timestamp == {34'h0, $past(tf)})
      else $error("tx timestamp mismatch");
   a_mark_copy: assert property (tx_body |=> tx_marks == $past(mk))
      else $error("tx marks mismatch");
   a_vec_ignored: assert property (tx_body ##0 !ev |=> !tx_upd_en && tx_offset == 8'h00)
      else $error("vector used without event flag");
   a_upd_off: assert property (tx_body ##0 (ev && !u4) |=> !tx_upd_en && !tx_peer_delay)
      else $error("update controls without enable");
   a_peer_pass: assert property (tx_body ##0 (ev && u4) |=> tx_upd_en && tx_peer_delay == $past(p5))
      else $error("peer delay control mismatch");
   a_rx_stamp: assert property (rx_take ##0 rx_in_sop |=> rx_valid && rx_data[290:261] == $past(rx_in_timestamp))
      else $error("rx timestamp mismatch");
   a_rx_flags: assert property (rx_take ##0 !rx_in_sop |=> rx_data[290:261] ==
      {16'h0, $past(rx_in_order), $past(rx_in_err_type), $past(rx_in_error)})
      else $error("rx flag field mismatch");
   a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx word lost while stalled");
endmodule : esf_codec_sva
bind esf_codec esf_codec_sva #(.DATA_W(DATA_W)) u_sva (.*);

// ==== tb/esf_fabric.sv ====
// Fabric-side model: sends transmit words, sinks receive words
`timescale 1ns/100ps
module esf_fabric #(
   parameter int DATA_W = 293
)
(
   input wire logic hclk,
   input wire logic tx_ready,
   input wire logic stall,
   output logic tx_valid,
   output logic tx_sop,
   output logic tx_eop,
   output logic [DATA_W-1:0] tx_data,
   output logic rx_ready
);
   logic ok = 1'b0;
   assign rx_ready = !stall;
   initial
   begin
      tx_valid = 1'b0;
      tx_sop = 1'b0;
      tx_eop = 1'b0;
      tx_data = '0;
   end
   task send(input logic sop, input logic eop, input logic [29:0] fld);
      int i;
      @(posedge hclk);
      tx_valid <= 1'b1;
      tx_sop <= sop;
      tx_eop <= eop;
      tx_data <= {2'b00, sop ? fld : {6'h00, fld[23:0]}, 5'h00, 256'h0};
      i = 0;
      ok = 1'b0;
      while (!ok && i < 50)
      begin
         @(posedge hclk);
         ok = tx_ready;
         i++;
      end
      tx_valid <= 1'b0;
      // Released bus must not look like the old word
      tx_data <= ~tx_data;
   endtask : send
endmodule : esf_fabric

// ==== tb/ethernet_sideband_flag_codec_bench.sv ====
// Self-checking bench for the sideband flag codec
`timescale 1ns/100ps
`include "esf_regs.svh"
module ethernet_sideband_flag_codec_bench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_sent = 1'b0, stall = 1'b0;
   logic rx_in_valid = 1'b0, rx_in_sop = 1'b0, rx_in_eop = 1'b0, rx_in_error = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [255:0] rx_in_data = 256'h0;
   logic [29:0] rx_in_timestamp = 30'h0;
   logic [7:0] rx_in_err_type = 8'h00, tx_offset;
   logic [4:0] rx_in_order = 5'h00;
   logic hready, hreadyout, hresp, irq, tx_valid, tx_sop, tx_eop, tx_ready, tx_status_valid;
   logic tx_upd_en, tx_peer_delay, tx_udp_fix, tx_time_upd, tx_corr_upd, rx_ready, rx_valid, rx_sop, rx_eop;
   logic [3:0] tx_status_tag;
   logic [63:0] tx_timestamp;
   logic [6:0] tx_marks;
   logic [292:0] tx_data, rx_data;
   int errors = 0, n_tests = 0;
   int b[3] = '{6, 15, 16};
   assign hready = hreadyout;
   esf_codec dut (.*);
   esf_fabric ptn (.*);
   initial
   begin
      forever #20 hclk = ~hclk;
   end
   task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task complete_run;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task rdy;
      int i;
      i = 0;
      do @(posedge hclk); while (!hreadyout && ++i < 50);
      if (hreadyout !== 1'b1)
      begin
         errors++;
         complete_run();
      end
   endtask : rdy
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      hsize <= 3'b010;
      rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
      rd = hrdata;
      #1;
      chk("hresp", 0, hresp);
   endtask : ahb
   task tx(input logic sop, input logic eop, input logic [29:0] fld);
      ptn.send(sop, eop, fld);
      chk("tx accepted", 1, ptn.ok);
      if (ptn.ok !== 1'b1)
         complete_run();
      #1;
   endtask : tx
   initial
   begin
      repeat (5000) @(posedge hclk);
      errors++;
      complete_run();
   end
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, `ESF_OFS_CTRL, 0);
      chk("ctrl", `ESF_CTRL_RST, rd);
      ahb(0, `ESF_OFS_MASK, 0);
      chk("mask", `ESF_MASK_RST, rd);
      ahb(0, 12'h020, 0);
      chk("unmapped", 0, rd);
      ahb(1, `ESF_OFS_CTRL, 1);
      chk("paused", 0, tx_ready);
      ahb(1, `ESF_OFS_CTRL, 0);
      $display("test registers done");
      tx(1, 0, 30'h1234567);
      chk("timestamp", {34'h0, 30'h1234567}, tx_timestamp);
      tx(0, 0, 30'h420b35);
      chk("upd", 1, tx_upd_en);
      chk("peer", 1, tx_peer_delay);
      chk("offset", 8'h16, tx_offset);
      chk("marks", 7'h21, tx_marks);
      tx(0, 0, 30'h000b35);
      chk("no event", 0, tx_upd_en);
      tx(0, 0, 30'h020b25);
      chk("no update", 0, {tx_peer_delay, tx_offset});
      tx(0, 0, 30'h028095);
      ahb(0, `ESF_OFS_STATUS, 0);
      chk("short offset", 32'h0000_0004, rd);
      ahb(0, `ESF_OFS_TXTAG, 0);
      chk("tag pending", 32'h0000_0055, rd);
      ahb(1, `ESF_OFS_STATUS, 32'h0000_0004);
      for (int k = 0; k < 3; k++)
      begin
         tx(0, k == 2, 30'h20815 | (30'h1 << b[k]));
         chk("mode", 3'b100 >> k, {tx_udp_fix, tx_time_upd, tx_corr_upd});
      end
      @(posedge hclk);
      tx_sent <= 1'b1;
      @(posedge hclk);
      tx_sent <= 1'b0;
      #1;
      chk("tag", 5'h15, {tx_status_valid, tx_status_tag});
      ahb(0, `ESF_OFS_TXTAG, 0);
      chk("tag cleared", 32'h0000_0005, rd);
      ahb(0, `ESF_OFS_TXSEEN, 0);
      chk("tx frames", 1, rd);
      chk("irq masked", 0, irq);
      ahb(1, `ESF_OFS_MASK, 1);
      chk("irq on", 1, irq);
      ahb(1, `ESF_OFS_STATUS, 1);
      chk("irq cleared", 0, irq);
      $display("test transmit done");
      @(posedge hclk);
      rx_in_valid <= 1'b1;
      rx_in_sop <= 1'b1;
      rx_in_timestamp <= 30'h2aaa5555;
      rx_in_data <= {8{32'hc0de0001}};
      @(posedge hclk);
      rx_in_sop <= 1'b0;
      rx_in_eop <= 1'b1;
      rx_in_error <= 1'b1;
      rx_in_err_type <= 8'h5a;
      rx_in_order <= 5'h13;
      #1;
      chk("rx stamp", 30'h2aaa5555, rx_data[290:261]);
      chk("rx first", 3'b110, {rx_valid, rx_sop, rx_eop});
      @(posedge hclk);
      stall <= 1'b1;
      rx_in_order <= 5'h07;
      #1;
      chk("rx flags", {16'h0, 5'h13, 8'h5a, 1'b1}, rx_data[290:261]);
      chk("rx last", 3'b101, {rx_valid, rx_sop, rx_eop});
      repeat (3) @(posedge hclk);
      rx_in_valid <= 1'b0;
      #1;
      chk("rx held", {16'h0, 5'h13, 8'h5a, 1'b1}, rx_data[290:261]);
      ahb(0, `ESF_OFS_STATUS, 0);
      chk("rx events", 32'h0000_000a, rd);
      ahb(0, `ESF_OFS_RXSEEN, 0);
      chk("rx frames", 1, rd);
      $display("test receive done");
      @(posedge hclk);
      hresetn <= 1'b0;
      #1;
      chk("reset outputs", 5'h10, {tx_ready, rx_valid, tx_status_valid, irq, tx_upd_en});
      chk("reset stamp", 0, tx_timestamp);
      @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, `ESF_OFS_MASK, 0);
      chk("mask after reset", `ESF_MASK_RST, rd);
      ahb(0, `ESF_OFS_STATUS, 0);
      chk("status after reset", 0, rd);
      $display("test reset done");
      complete_run();
   end
endmodule : ethernet_sideband_flag_codec_bench
